/* logic/pstcc_pkg.sv */
// Purpose: Shared constants and carrier types for the pulse timer start and capture control.
// Assumes: One system clock; all control bits arrive as plain ports.
// Notes: Field codes match the software-visible encodings of the control fields.
package pstcc_pkg;

    // Width of the up counter and of the period value.
    localparam int CNT_W = 10;
    // Width of a capture register as software sees it.
    localparam int CAP_REG_W = 16;
    // Value of the counter and of captured data after reset.
    localparam logic [CNT_W-1:0] CNT_RST = 10'h000;
    // Zero fill for the capture bits above the counter width.
    localparam logic [CAP_REG_W-CNT_W-1:0] CAP_PAD = 6'h00;

    // Start source field codes.
    localparam logic [1:0] SRC_CMD_CAP = 2'h0;
    localparam logic [1:0] SRC_CMD_TRIG = 2'h1;
    localparam logic [1:0] SRC_TRIG = 2'h2;

    // Stop mode field codes.
    localparam logic [1:0] STOP_INIT = 2'h0;
    localparam logic [1:0] STOP_HOLD = 2'h1;
    localparam logic [1:0] STOP_ONE = 2'h2;

    // Control bits as software drives them.
    typedef struct packed {
        logic count_run_bit;
        logic run_write;
        logic [1:0] stop_mode_select;
        logic [1:0] start_source_select;
        logic trigger_edge_select;
        logic [CNT_W-1:0] period;
    } pstcc_ctrl_t;

    // One-cycle read strobes for the four capture bytes.
    typedef struct packed {
        logic rise_capture_low;
        logic rise_capture_high;
        logic fall_capture_low;
        logic fall_capture_high;
    } pstcc_rd_t;

    // Status of the block shown to software.
    typedef struct packed {
        logic counting;
        logic waiting;
        logic one_time_done;
        logic cap_locked;
    } pstcc_status_t;

    // Timer states.
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_COUNT,
        ST_WAIT,
        ST_DONE
    } pstcc_state_t;

endpackage : pstcc_pkg

/* logic/pstcc_pin_sync.sv */
// Purpose: Brings the trigger pin into the system clock and finds its edges.
// Assumes: The pin is asynchronous to i_clk_sys.
// Notes: Edges appear two to three cycles after the pin moves.
`timescale 1ns/100ps
module pstcc_pin_sync
(
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_pin,
    output logic o_level,
    output logic o_rise,
    output logic o_fall
);
    import pstcc_pkg::*;

    // First stage; only the second stage reads it.
    logic meta_reg;
    // Second stage, the settled level.
    logic sync_reg;
    // Settled level one cycle earlier, for edge finding.
    logic prev_reg;

    // Two-stage synchroniser plus a delay stage.
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_b)
        begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            prev_reg <= 1'b0;
        end
        else
        begin
            meta_reg <= i_pin;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    // Edges compare settled samples only, never the first stage.
    assign o_level = sync_reg;
    assign o_rise = sync_reg & ~prev_reg;
    assign o_fall = ~sync_reg & prev_reg;

endmodule : pstcc_pin_sync

/* logic/pstcc_top.sv */
// Purpose: Start, stop and capture control of a 10-bit up counter.
// Assumes: Control bits are steady between writes; run_write pulses on a write of 1.
// Notes: Waveform generation lies outside; this block pulses o_outputs_init instead.
// Contract
// R1: Command run write clears counter, starts counting.
// R2: At period, clear; continue or halt per mode.
// R3: Run write before period end restarts counter.
// R4: Start source selects command, command-plus-trigger, trigger.
// R5: Start edge starts; clear level holds counter.
// R6: Clear level at command waits for start edge.
// R7: Trigger-only run write merely arms, no init.
// R8: Rising edge captures A, falling captures B.
// R9: Buffer moves to capture registers at period.
// R10: Last edge in a period wins.
// R11: Software reads A low, A high, B low, B high.
// R12: Capture reads lock; B high read unlocks.
// R13: Software dummy-reads captures in first period.
// R14: Capture only while run bit set.
// R15: After one-time stop, no capture or trigger.
// R16: Edge select 0: fall starts, high clears.
// R17: Edge select 1: rise starts, low clears.
// R18: One-time mode: stop triggers only, immediate stop.
// R19: Run bit clear ignores all triggers.
// R20: Stop mode 00 init, 01 hold, 10 one-time.
// R21: Capture registers are 10 bits, upper zero.
// R22: Pin synchronised; capture takes current counter.
`timescale 1ns/100ps
module pstcc_top
(
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire pstcc_pkg::pstcc_ctrl_t i_ctrl,
    input wire pstcc_pkg::pstcc_rd_t i_cap_rd,
    input wire logic i_trigger_input_pin,
    output logic [pstcc_pkg::CNT_W-1:0] o_counter,
    output pstcc_pkg::pstcc_status_t o_status,
    output logic o_period_match_irq,
    output logic o_trigger_start_irq,
    output logic o_outputs_init,
    output logic [pstcc_pkg::CAP_REG_W-1:0] o_rise_capture_reg,
    output logic [pstcc_pkg::CAP_REG_W-1:0] o_fall_capture_reg
);
    import pstcc_pkg::*;

    // Synchronised pin level and edges.
    logic pin_lvl;
    logic pin_rise;
    logic pin_fall;
    // Current and next timer state.
    pstcc_state_t state_reg;
    pstcc_state_t state_next;
    // Up counter.
    logic [CNT_W-1:0] cnt_reg;
    // Capture buffers and readable capture registers.
    logic [CNT_W-1:0] buf_a_reg;
    logic [CNT_W-1:0] buf_b_reg;
    logic [CNT_W-1:0] cap_a_reg;
    logic [CNT_W-1:0] cap_b_reg;
    // Read-order interlock.
    logic lock_reg;
    // Registered event pulses.
    logic per_irq_reg;
    logic trg_irq_reg;
    logic init_reg;
    // Decoded control and events.
    logic run;
    logic trig_mode;
    logic one_time;
    logic clr_lvl;
    logic st_edge;
    logic pe;
    logic cap_en;
    logic restart;
    logic trig_start;
    logic init_now;

    // The pin passes a synchroniser before any decision is made.
    pstcc_pin_sync u_sync // R22
    (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_pin(i_trigger_input_pin),
        .o_level(pin_lvl),
        .o_rise(pin_rise),
        .o_fall(pin_fall)
    );

    // Control decode.
    assign run = i_ctrl.count_run_bit;
    assign trig_mode = (i_ctrl.start_source_select == SRC_CMD_TRIG) ||
                       (i_ctrl.start_source_select == SRC_TRIG); // R4
    assign one_time = (i_ctrl.stop_mode_select == STOP_ONE); // R20
    // Edge select 0 clears on high, 1 clears on low.
    assign clr_lvl = pin_lvl ^ i_ctrl.trigger_edge_select; // R16 R17
    // Edge select 0 starts on fall, 1 starts on rise.
    assign st_edge = i_ctrl.trigger_edge_select ? pin_rise : pin_fall; // R16 R17
    // Period end is seen only while counting.
    assign pe = (state_reg == ST_COUNT) && (cnt_reg == i_ctrl.period); // R2
    // Captures only in command-with-capture mode while running.
    assign cap_en = run && (state_reg == ST_COUNT) &&
                    (i_ctrl.start_source_select == SRC_CMD_CAP); // R8 R14

    // Next-state decision. Run bit clear overrides everything, so pin
    // activity while stopped can never start or stop the counter.
    always_comb
    begin
        state_next = state_reg;
        restart = 1'b0;
        trig_start = 1'b0;
        init_now = 1'b0;
        if (!run)
        begin
            // Stopped: triggers ignored; init only for stop mode 00.
            state_next = ST_IDLE; // R19
            init_now = (state_reg != ST_IDLE) &&
                       (i_ctrl.stop_mode_select == STOP_INIT); // R20
        end
        else if (i_ctrl.run_write)
        begin
            if (i_ctrl.start_source_select == SRC_TRIG)
            begin
                // Arms only; outputs are left alone.
                state_next = ST_WAIT; // R7
            end
            else if ((i_ctrl.start_source_select == SRC_CMD_TRIG) && clr_lvl)
            begin
                // Trigger has precedence over the command.
                state_next = ST_WAIT; // R6
                init_now = 1'b1;
            end
            else
            begin
                // Command start or restart from zero.
                state_next = ST_COUNT; // R1 R3
                restart = 1'b1;
                init_now = 1'b1;
            end
        end
        else
        begin
            case (state_reg)
                ST_COUNT:
                begin
                    if (trig_mode && clr_lvl)
                    begin
                        // Stop trigger: clear at once, init outputs.
                        state_next = one_time ? ST_DONE : ST_WAIT; // R5 R18
                        init_now = 1'b1;
                    end
                    else if (pe)
                    begin
                        // One-time mode halts at period end.
                        state_next = one_time ? ST_DONE : ST_COUNT; // R2
                    end
                    else if (trig_mode && st_edge && !one_time)
                    begin
                        // A fresh start edge restarts; one-time ignores it.
                        restart = 1'b1; // R5 R18
                        trig_start = 1'b1;
                        init_now = 1'b1;
                    end
                end
                ST_WAIT:
                begin
                    if (trig_mode && st_edge)
                    begin
                        // Start edge begins counting from zero.
                        state_next = ST_COUNT; // R5 R6
                        restart = 1'b1;
                        trig_start = 1'b1;
                        init_now = 1'b1;
                    end
                end
                ST_DONE:
                begin
                    // Finished one-time run accepts no trigger.
                    state_next = ST_DONE; // R15
                end
                default:
                begin
                    state_next = state_reg;
                end
            endcase
        end
    end

    // State register.
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_b)
            state_reg <= ST_IDLE;
        else
            state_reg <= state_next;
    end

    // Counter: held at zero outside counting, cleared on start and at
    // period end. Clearing on the start cycle means the first count
    // after a start is always zero, whatever value was left behind.
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_b)
            cnt_reg <= CNT_RST;
        else if ((state_next != ST_COUNT) || restart || pe)
            cnt_reg <= CNT_RST; // R1 R2 R3 R5
        else
            cnt_reg <= cnt_reg + 10'h001;
    end

    // Event pulses, one cycle each.
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_b)
        begin
            per_irq_reg <= 1'b0;
            trg_irq_reg <= 1'b0;
            init_reg <= 1'b0;
        end
        else
        begin
            per_irq_reg <= pe; // R2
            trg_irq_reg <= trig_start; // R6
            init_reg <= init_now; // R16 R17
        end
    end

    // Capture buffers take the counter on the detect cycle; a later edge
    // of the same kind simply overwrites, so the last one wins.
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_b)
        begin
            buf_a_reg <= CNT_RST;
            buf_b_reg <= CNT_RST;
        end
        else if (cap_en)
        begin
            if (pin_rise)
                buf_a_reg <= cnt_reg; // R8 R10 R22
            if (pin_fall)
                buf_b_reg <= cnt_reg; // R8 R10 R22
        end
    end

    // Transfer at period end unless software is mid-read. Without an
    // edge the old buffer is moved again, which repeats the old value.
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_b)
        begin
            cap_a_reg <= CNT_RST;
            cap_b_reg <= CNT_RST;
        end
        else if (cap_en && pe && !lock_reg)
        begin
            cap_a_reg <= buf_a_reg; // R9 R12
            cap_b_reg <= buf_b_reg; // R9 R12
        end
    end

    // Interlock: any read but the last byte locks; the last byte frees.
    // Software must still read in order and dummy-read after a start.
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_b)
            lock_reg <= 1'b0;
        else if (i_cap_rd.fall_capture_high)
            lock_reg <= 1'b0; // R12 R11
        else if (i_cap_rd.rise_capture_low || i_cap_rd.rise_capture_high ||
                 i_cap_rd.fall_capture_low)
            lock_reg <= 1'b1; // R12 R13
    end

    // Outputs.
    assign o_counter = cnt_reg;
    assign o_status = {(state_reg == ST_COUNT),
                       (state_reg == ST_WAIT),
                       (state_reg == ST_DONE),
                       lock_reg};
    assign o_period_match_irq = per_irq_reg;
    assign o_trigger_start_irq = trg_irq_reg;
    assign o_outputs_init = init_reg;
    // Upper capture bits always read as zero.
    assign o_rise_capture_reg = {CAP_PAD, cap_a_reg}; // R21
    assign o_fall_capture_reg = {CAP_PAD, cap_b_reg}; // R21

    // Checks on the block's own behaviour.
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_b);

    property p_cmd_start;
        run && i_ctrl.run_write && (i_ctrl.start_source_select == SRC_CMD_CAP)
        |=> (cnt_reg == CNT_RST) && (state_reg == ST_COUNT) ##1 (cnt_reg == 10'h001) || !run;
    endproperty
    a_cmd_start: assert property (p_cmd_start) else $error("command start failed"); // R1 R3

    property p_period_wrap;
        pe && run && !i_ctrl.run_write && !(trig_mode && clr_lvl)
        |=> (cnt_reg == CNT_RST) && o_period_match_irq;
    endproperty
    a_period_wrap: assert property (p_period_wrap) else $error("no wrap at period"); // R2

    property p_one_time;
        pe && run && one_time && !i_ctrl.run_write
        |=> (state_reg == ST_DONE);
    endproperty
    a_one_time: assert property (p_one_time) else $error("one-time did not halt"); // R20

    property p_arm_only;
        run && i_ctrl.run_write && (i_ctrl.start_source_select == SRC_TRIG)
        |=> (state_reg == ST_WAIT) && !o_outputs_init;
    endproperty
    a_arm_only: assert property (p_arm_only) else $error("trigger-only write started"); // R7

    property p_clear_hold;
        run && trig_mode && clr_lvl && (state_reg != ST_DONE)
        |=> (cnt_reg == CNT_RST) && (state_reg != ST_COUNT);
    endproperty
    a_clear_hold: assert property (p_clear_hold) else $error("clear level not held"); // R5

    property p_edge_start;
        run && !i_ctrl.run_write && (state_reg == ST_WAIT) && trig_mode && st_edge
        |=> o_trigger_start_irq && (state_reg == ST_COUNT) && (cnt_reg == CNT_RST);
    endproperty
    a_edge_start: assert property (p_edge_start) else $error("start edge missed"); // R6

    property p_capture;
        cap_en && pin_rise |=> (buf_a_reg == $past(cnt_reg));
    endproperty
    a_capture: assert property (p_capture) else $error("rise capture wrong"); // R8

    property p_locked;
        lock_reg && !i_cap_rd.fall_capture_high |=> $stable(cap_a_reg) && $stable(cap_b_reg);
    endproperty
    a_locked: assert property (p_locked) else $error("locked capture changed"); // R12

    property p_transfer;
        cap_en && pe && !lock_reg |=> (cap_b_reg == $past(buf_b_reg));
    endproperty
    a_transfer: assert property (p_transfer) else $error("period transfer lost"); // R9

    property p_run_off;
        !run |=> (state_reg == ST_IDLE) && (cnt_reg == CNT_RST);
    endproperty
    a_run_off: assert property (p_run_off) else $error("counting while stopped"); // R19

    property p_done_stays;
        (state_reg == ST_DONE) && run && !i_ctrl.run_write |=> (state_reg == ST_DONE);
    endproperty
    a_done_stays: assert property (p_done_stays) else $error("trigger after stop"); // R15

    c_trig_start: cover property (o_trigger_start_irq);
    c_period: cover property (o_period_match_irq ##1 o_status.counting);
    c_unlock: cover property (lock_reg ##1 !lock_reg);
    c_done: cover property (state_reg == ST_DONE);

endmodule : pstcc_top

/* test/pstcc_trig_src.sv */
// Purpose: Model of the external signal source on the trigger input pin.
// Assumes: The pin is always driven, so it never floats.
// Notes: Levels change just after a rising clock edge, as a real source is unrelated in phase.
`timescale 1ns/100ps
module pstcc_trig_src
(
    input wire logic i_clk_sys,
    output logic o_pin
);
    // The pin rests low until the bench asks for a level.
    initial
    begin
        o_pin = 1'b0;
    end

    // Moves the pin one small step after the next edge, so sampling never races.
    task automatic set_level(input logic v);
        @(posedge i_clk_sys);
        #1;
        o_pin = v;
    endtask : set_level
endmodule : pstcc_trig_src

/* test/tb_pstcc_top.sv */
// Purpose: Self-checking bench for the start, stop and capture control.
// Assumes: Pin edges are detected two cycles after the pin moves.
// Notes: Inputs change 1 ns after each rising edge; outputs are read at that moment.
`timescale 1ns/100ps
module tb_pstcc_top;
    import pstcc_pkg::*;
    logic i_clk_sys; // System clock, 8 ns period.
    logic i_rst_b; // Synchronous reset, active low.
    pstcc_ctrl_t ctrl; // Software control bits.
    pstcc_rd_t rd; // Capture byte read strobes.
    logic pin; // Trigger pin from the source model.
    logic [CNT_W-1:0] cnt;
    pstcc_status_t st;
    logic p_irq;
    logic t_irq;
    logic init_p;
    logic [CAP_REG_W-1:0] cap_a;
    logic [CAP_REG_W-1:0] cap_b;
    int mismatches; // Failed comparisons.
    int n_tests; // All comparisons.
    logic [CNT_W-1:0] ea; // Expected rise capture.
    logic [CNT_W-1:0] eb; // Expected fall capture.
    logic [CNT_W-1:0] eb2; // Fall capture held back by the lock.

    pstcc_top u_dut (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_ctrl(ctrl), .i_cap_rd(rd),
        .i_trigger_input_pin(pin), .o_counter(cnt), .o_status(st), .o_period_match_irq(p_irq),
        .o_trigger_start_irq(t_irq), .o_outputs_init(init_p), .o_rise_capture_reg(cap_a),
        .o_fall_capture_reg(cap_b));

    pstcc_trig_src u_src (.i_clk_sys(i_clk_sys), .o_pin(pin));

    // Free-running system clock.
    initial
    begin
        i_clk_sys = 1'b0;
        forever #4 i_clk_sys = ~i_clk_sys;
    end

    // Compares one value and counts the outcome.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    // Advances n edges and stops just after the last one.
    task automatic tick(input int n);
        repeat (n)
        begin
            @(posedge i_clk_sys);
            #1;
        end
    endtask : tick

    // One-cycle write of 1 to the run bit.
    task automatic start();
        ctrl.run_write = 1'b1;
        tick(1);
        ctrl.run_write = 1'b0;
    endtask : start

    // One-cycle read strobe of capture byte k, then an idle cycle so strobes never merge.
    task automatic rd_byte(input int k);
        rd = pstcc_rd_t'(4'b1000 >> k);
        tick(1);
        rd = '0;
        tick(1);
    endtask : rd_byte

    // Moves the pin; the capture expected is the count two cycles later.
    task automatic pin_to(input logic v, output logic [CNT_W-1:0] e);
        u_src.set_level(v);
        e = cnt + 10'h002;
    endtask : pin_to

    // Waits for a period pulse (per=1) or trigger pulse; a hang ends the run.
    task automatic wait_hi(input bit per, input int lim);
        for (int i = 0; i < lim; i++)
        begin
            tick(1);
            if ((per ? p_irq : t_irq) === 1'b1)
                return;
        end
        mismatches++;
        $display("Error %0t: wait ran out", $time);
        give_verdict();
    endtask : wait_hi

    // Single exit of the run.
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict

    // Main sequence.
    initial
    begin
        i_rst_b = 1'b0;
        ctrl = '0;
        rd = '0;
        tick(5);
        i_rst_b = 1'b1;
        check(cnt, 16'h0000);
        check(cap_a, 16'h0000);
        check(st, 16'h0000);
        // Command start, continuous, period 5 gives six counts a period.
        ctrl.count_run_bit = 1'b1;
        ctrl.period = 10'h005;
        start();
        check({st.counting, init_p, cnt}, {2'b11, 10'h000});
        tick(5);
        check({p_irq, cnt}, {1'b0, 10'h005});
        tick(1);
        check({p_irq, st.counting, cnt}, {2'b11, 10'h000});
        tick(2);
        start();
        check(cnt, 16'h0000);
        // Let an edge pass so the next write is a fresh pulse, not a held one.
        tick(1);
        // One-time output halts at period end.
        ctrl.stop_mode_select = STOP_ONE;
        start();
        tick(6);
        check({p_irq, st.one_time_done, st.counting, cnt}, {3'b110, 10'h000});
        ctrl.count_run_bit = 1'b0;
        tick(1);
        // Capture mode, period 63; the lock is cleared by a dummy read first.
        ctrl.count_run_bit = 1'b1;
        ctrl.stop_mode_select = STOP_INIT;
        ctrl.start_source_select = SRC_CMD_CAP;
        ctrl.period = 10'h03F;
        start();
        rd_byte(3);
        pin_to(1'b1, ea);
        tick(8);
        pin_to(1'b0, eb);
        tick(5);
        pin_to(1'b1, ea);
        wait_hi(1'b1, 80);
        check(cap_a, {CAP_PAD, ea});
        check(cap_b, {CAP_PAD, eb});
        rd_byte(0);
        check(st.cap_locked, 1'b1);
        pin_to(1'b0, eb2);
        wait_hi(1'b1, 80);
        check(cap_b, {CAP_PAD, eb});
        rd_byte(1);
        rd_byte(2);
        rd_byte(3);
        check(st.cap_locked, 1'b0);
        wait_hi(1'b1, 80);
        check(cap_b, {CAP_PAD, eb2});
        check(cap_a, {CAP_PAD, ea});
        ctrl.count_run_bit = 1'b0;
        tick(1);
        // Command plus trigger, both edge polarities; a command at clear level waits.
        ctrl.start_source_select = SRC_CMD_TRIG;
        for (int s = 0; s < 2; s++)
        begin
            ctrl.trigger_edge_select = s[0];
            // First pass stops with outputs initialised, second with outputs held.
            ctrl.stop_mode_select = s[0] ? STOP_HOLD : STOP_INIT;
            ctrl.count_run_bit = 1'b1;
            u_src.set_level(~s[0]);
            tick(4);
            start();
            check({st.waiting, st.counting}, 2'b10);
            tick(8);
            check({p_irq, cnt}, 16'h0000);
            u_src.set_level(s[0]);
            wait_hi(1'b0, 8);
            check({st.counting, init_p, cnt}, {2'b11, 10'h000});
            tick(3);
            u_src.set_level(~s[0]);
            tick(4);
            check({st.waiting, cnt}, {1'b1, 10'h000});
            ctrl.count_run_bit = 1'b0;
            tick(1);
            check(init_p, s == 0);
        end
        // Trigger-only, one-time: the command only arms, a stop trigger ends it.
        ctrl.start_source_select = SRC_TRIG;
        ctrl.stop_mode_select = STOP_ONE;
        ctrl.trigger_edge_select = 1'b0;
        ctrl.count_run_bit = 1'b1;
        u_src.set_level(1'b0);
        tick(4);
        start();
        check({st.waiting, st.counting, init_p}, 3'b100);
        u_src.set_level(1'b1);
        tick(4);
        u_src.set_level(1'b0);
        wait_hi(1'b0, 8);
        check(st.counting, 1'b1);
        tick(3);
        u_src.set_level(1'b1);
        tick(4);
        check({st.one_time_done, st.counting, cnt}, {2'b10, 10'h000});
        u_src.set_level(1'b0);
        tick(5);
        check({st.one_time_done, st.counting}, 2'b10);
        // A reset in mid-run must clear the state and the captured data alike.
        i_rst_b = 1'b0;
        tick(2);
        i_rst_b = 1'b1;
        check(st, 16'h0000);
        check(cap_a, 16'h0000);
        check(cap_b, 16'h0000);
        // Run bit clear: pin moves and a run write are both ignored.
        ctrl.count_run_bit = 1'b0;
        ctrl.start_source_select = SRC_CMD_TRIG;
        tick(2);
        u_src.set_level(1'b1);
        tick(4);
        u_src.set_level(1'b0);
        for (int i = 0; i < 6; i++)
        begin
            tick(1);
            check(t_irq, 1'b0);
        end
        start();
        check(st.counting, 1'b0);
        give_verdict();
    end
endmodule : tb_pstcc_top
